// ### shared/tss_pkg.sv
package tss_pkg;
   // ----------------------------------------
   // Sizes, offsets and field positions
   // ----------------------------------------
   localparam int TSS_FIFO_DEPTH = 8;
   localparam int TSS_DM_AW = 12;
   localparam logic [11:0] TSS_MODE_IDX = 12'h105;
   localparam logic [11:0] TSS_STAT_IDX = 12'h106;
   localparam logic [31:0] TSS_MODE_ADDR = {18'h00000, TSS_MODE_IDX, 2'h0};
   localparam logic [31:0] TSS_STAT_ADDR = {18'h00000, TSS_STAT_IDX, 2'h0};
   localparam int TSS_SREN_POS = 7;
   localparam int TSS_DBUF_POS = 0;
   localparam logic [7:0] TSS_MODE_RST = 8'h00;
   localparam logic [1:0] TSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] TSS_RESP_SLVERR = 2'h2;
   localparam logic [1:0] TSS_DIBIT_CODE = 2'h1;
   localparam logic [2:0] TSS_NIB_CODE = 3'h1;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {TSS_BYTE, TSS_BIT, TSS_DIBIT, TSS_NIBBLE} tss_type_e;
   typedef enum logic {TSS_ST_IDLE, TSS_ST_READ} tss_eng_e;

   typedef struct packed {
      logic to_dir;
      logic page_select_bit;
      logic [TSS_DM_AW-1:0] addr;
      logic [6:0] subrate;
      logic [7:0] data;
   } tss_slot_s;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] mask;
   } tss_piece_s;

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic tss_type_e tss_type(input logic [6:0] f);
      if (f[6]) return TSS_BIT;
      if (f[6:5] == TSS_DIBIT_CODE) return TSS_DIBIT;
      if (f[6:4] == TSS_NIB_CODE) return TSS_NIBBLE;
      return TSS_BYTE;
   endfunction

   // Mask marks the only bits a write may change, so several pieces can share a byte
   function automatic tss_piece_s tss_shuffle(input logic [7:0] b, input logic [6:0] f, input logic en);
      tss_piece_s p;
      logic [2:0] s;
      logic [2:0] d;
      p.data = b;
      p.mask = 8'hff;
      s = 3'h0;
      d = 3'h0;
      if (en) begin
         case (tss_type(f))
            TSS_BIT: begin
               s = f[5:3];
               d = f[2:0];
               p.mask = 8'h01 << d;
               p.data = (b[s] ? 8'h01 : 8'h00) << d;
            end
            TSS_DIBIT: begin
               s = {f[4:3], 1'b0};
               d = {f[1:0], 1'b0};
               p.mask = 8'h03 << d;
               p.data = {6'h00, b[s +: 2]} << d;
            end
            TSS_NIBBLE: begin
               s = {f[3], 2'h0};
               d = {f[0], 2'h0};
               p.mask = 8'h0f << d;
               p.data = {4'h0, b[s +: 4]} << d;
            end
            default: begin
            end
         endcase
      end
      return p;
   endfunction

   // Returns {status hit, mode hit}
   function automatic logic [1:0] tss_decode(input logic [31:0] a);
      return {a == TSS_STAT_ADDR, a == TSS_MODE_ADDR};
   endfunction
endpackage

// ### verilog/tss_shuffler.sv
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps

// ----------------------------------------
// Slot FIFO
// ----------------------------------------
module tss_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic vld;
      logic rdy;
   } tss_fifo_s;
   localparam tss_fifo_s FIFO_RST = '{rdy: 1'b1, default: '0};
   tss_fifo_s q;
   tss_fifo_s n;
   logic push;
   logic pop;
   always_comb begin
      n = q;
      push = in_valid && q.rdy;
      pop = q.vld && out_ready;
      if (push) begin
         n.mem[q.wp] = in_data;
         n.wp = AW'(q.wp + 1'b1);
      end
      if (pop) begin
         n.rp = AW'(q.rp + 1'b1);
      end
      if (push && !pop) begin
         n.cnt = (AW+1)'(q.cnt + 1'b1);
      end else if (pop && !push) begin
         n.cnt = (AW+1)'(q.cnt - 1'b1);
      end
      // Ready and valid are registered so neither side sees a combinational path
      n.rdy = n.cnt != (AW+1)'(DEPTH);
      n.vld = n.cnt != '0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= FIFO_RST;
      end else if (ce) begin
         q <= n;
      end
   end

   assign in_ready = q.rdy;
   assign out_valid = q.vld;
   assign out_data = q.mem[q.rp];
endmodule // tss_fifo

// ----------------------------------------
// Subrate shuffler top
// ----------------------------------------
module tss_shuffler import tss_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic frame_pulse,
   input wire logic in_valid,
   output logic in_ready,
   input wire tss_slot_s in_slot,
   input wire logic mem_ready,
   output logic mem_we,
   output logic mem_re,
   output logic mem_page,
   output logic [TSS_DM_AW-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic [7:0] mem_wmask,
   input wire logic mem_rvalid,
   input wire logic [7:0] mem_rdata,
   output logic tx_valid,
   output logic [7:0] tx_byte
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [1:0] aw_sel;
      logic aw_bad;
      logic [7:0] wdata_l;
      logic wstrb_l;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] mode;
      logic active_page;
      logic [15:0] wr_count;
      tss_eng_e st;
      logic mem_we;
      logic mem_re;
      logic mem_page;
      logic [TSS_DM_AW-1:0] mem_addr;
      logic [7:0] mem_wdata;
      logic [7:0] mem_wmask;
      logic tx_valid;
      logic [7:0] tx_byte;
   } tss_top_s;
   localparam tss_top_s TOP_RST = '{mode: TSS_MODE_RST, st: TSS_ST_IDLE, default: '0};
   tss_top_s q;
   tss_top_s n;
   tss_slot_s head;
   logic head_valid;
   logic pop;
   logic sren;
   logic dbuf;
   logic [1:0] rsel;
   tss_piece_s piece;
   logic sub_active;
   // ----------------------------------------
   // Slot buffer
   // ----------------------------------------
   // A stalled memory holds back the FIFO and in turn the slot source
   tss_fifo #(.W($bits(tss_slot_s)), .DEPTH(TSS_FIFO_DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(in_slot),
      .out_valid(head_valid),
      .out_ready(pop),
      .out_data(head)
   );
   assign sren = q.mode[TSS_SREN_POS];
   assign dbuf = q.mode[TSS_DBUF_POS];
   assign pop = head_valid && mem_ready && (q.st == TSS_ST_IDLE);
   assign piece = tss_shuffle(head.data, head.subrate, sren);
   assign sub_active = sren && (tss_type(head.subrate) != TSS_BYTE);
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n = q;
      rsel = tss_decode(araddr);
      n.mem_we = 1'b0;
      n.mem_re = 1'b0;
      n.tx_valid = 1'b0;
      // Register write channel, address and data in either order
      if (awvalid && q.awready) begin
         n.aw_got = 1'b1;
         n.aw_sel = tss_decode(awaddr);
         n.aw_bad = tss_decode(awaddr) == 2'h0;
      end
      if (wvalid && q.wready) begin
         n.w_got = 1'b1;
         n.wdata_l = wdata[7:0];
         n.wstrb_l = wstrb[0];
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = q.aw_bad ? TSS_RESP_SLVERR : TSS_RESP_OKAY;
         if (q.aw_sel[0] && q.wstrb_l) begin
            n.mode = q.wdata_l;
         end
      end
      if (q.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;
      // Register read channel
      if (arvalid && q.arready) begin
         n.rvalid = 1'b1;
         n.rresp = rsel == 2'h0 ? TSS_RESP_SLVERR : TSS_RESP_OKAY;
         n.rdata = 32'h00000000;
         if (rsel[0]) begin
            n.rdata = {24'h000000, q.mode};
         end else if (rsel[1]) begin
            n.rdata = {q.wr_count, 14'h0000, q.st == TSS_ST_READ, q.active_page};
         end
      end else if (q.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
      n.arready = !n.rvalid;
      // Frame boundary swaps the active and inactive page
      if (frame_pulse && dbuf) begin
         n.active_page = !q.active_page;
      end
      // Slot engine
      case (q.st)
         TSS_ST_IDLE: begin
            if (pop && !head.to_dir) begin
               // Masked write: other pieces packed in this byte survive
               n.mem_we = 1'b1;
               n.mem_addr = head.addr;
               n.mem_wdata = piece.data;
               n.mem_wmask = piece.mask;
               n.mem_page = dbuf && (sub_active ? (q.active_page ^ head.page_select_bit) : q.active_page);
               n.wr_count = 16'(q.wr_count + 1'b1);
            end else if (pop) begin
               n.mem_re = 1'b1;
               n.mem_addr = head.addr;
               n.mem_page = dbuf && (q.active_page ^ head.page_select_bit);
               n.st = TSS_ST_READ;
            end
         end
         TSS_ST_READ: begin
            if (mem_rvalid) begin
               n.tx_valid = 1'b1;
               n.tx_byte = mem_rdata;
               n.st = TSS_ST_IDLE;
            end
         end
         default: begin
            n.st = TSS_ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= TOP_RST;
      end else if (ce) begin
         q <= n;
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arready;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign mem_we = q.mem_we;
   assign mem_re = q.mem_re;
   assign mem_page = q.mem_page;
   assign mem_addr = q.mem_addr;
   assign mem_wdata = q.mem_wdata;
   assign mem_wmask = q.mem_wmask;
   assign tx_valid = q.tx_valid;
   assign tx_byte = q.tx_byte;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic issue;
   logic exp_page;
   assign issue = ce && pop;
   assign exp_page = q.active_page ^ head.page_select_bit;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_from_issue;
      issue && !head.to_dir;
   endsequence
   sequence s_to_issue;
      issue && head.to_dir;
   endsequence
   sequence s_mode_wr;
      ce && q.aw_got && q.w_got && !q.bvalid && q.aw_sel[0] && q.wstrb_l;
   endsequence
   shuffle_write_a: assert property (s_from_issue |=> mem_we && {mem_wdata, mem_wmask} == $past(piece))
      else $error("shuffled write mismatch");
   from_no_read_a: assert property (s_from_issue |=> !mem_re && mem_addr == $past(head.addr))
      else $error("from entry started a read");
   to_no_write_a: assert property (s_to_issue |=> mem_re && !mem_we ##1 q.st == TSS_ST_READ)
      else $error("to entry wrote memory");
   to_whole_byte_a: assert property (ce && q.st == TSS_ST_READ && mem_rvalid
      |=> tx_valid && tx_byte == $past(mem_rdata))
      else $error("to byte altered");
   bypass_full_a: assert property (s_from_issue and !sren
      |=> mem_wmask == 8'hff && mem_wdata == $past(head.data))
      else $error("byte not written whole while disabled");
   bit_onehot_a: assert property (s_from_issue and (sren && head.subrate[6]) |=> $onehot(mem_wmask))
      else $error("bit mask not one hot");
   pair_mask_a: assert property (s_from_issue and (sren && head.subrate[6:5] == 2'h1)
      |=> mem_wmask inside {8'h03, 8'h0c, 8'h30, 8'hc0})
      else $error("di-bit mask wrong");
   nibble_mask_a: assert property (s_from_issue and (sren && head.subrate[6:4] == 3'h1)
      |=> mem_wmask inside {8'h0f, 8'hf0})
      else $error("nibble mask wrong");
   byte_mode_a: assert property (s_from_issue and (head.subrate[6:4] == 3'h0) |=> mem_wmask == 8'hff)
      else $error("byte type not whole");
   dbuf_page_a: assert property (s_from_issue and (sub_active && dbuf) |=> mem_page == $past(exp_page))
      else $error("subrate page wrong");
   enable_reg_a: assert property (s_mode_wr |=> bvalid && sren == $past(q.wdata_l[TSS_SREN_POS]))
      else $error("enable bit not stored");
endmodule // tss_shuffler

// ### tb/tss_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Two-page data memory, slow reads
// ----------------------------------------
module tss_mem_model #(
   parameter int LAT = 3
) (
   input wire logic aclk,
   input wire logic stall,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic mem_page,
   input wire logic [11:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_wmask,
   output logic mem_ready,
   output logic mem_rvalid,
   output logic [7:0] mem_rdata
);
   logic [7:0] m [2][4096];
   logic [7:0] last_q;
   logic pg_q;
   logic [11:0] ad_q;
   int cnt_q;
   initial begin
      foreach (m[p, a]) m[p][a] = 8'h00;
      last_q = 8'h00;
      cnt_q = 0;
      mem_rvalid = 1'b0;
      mem_rdata = 8'hff;
   end
   assign mem_ready = !stall;
   always @(posedge aclk) begin
      if (mem_we === 1'b1) begin
         // Only masked bits change, so pieces packed earlier survive
         m[mem_page][mem_addr] <= (m[mem_page][mem_addr] & ~mem_wmask) | (mem_wdata & mem_wmask);
      end
      if (mem_re === 1'b1) begin
         pg_q <= mem_page;
         ad_q <= mem_addr;
         cnt_q <= LAT;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end
      // Outside the answer the data line flips, so a stale byte is never mistaken for data
      if (cnt_q == 1) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= m[pg_q][ad_q];
         last_q <= m[pg_q][ad_q];
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata <= ~last_q;
      end
   end
endmodule // tss_mem_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import tss_pkg::*;;
   logic aclk, aresetn, awvalid, wvalid, arvalid, frame_pulse, in_valid, stall;
   logic awready, wready, bvalid, arready, rvalid, in_ready, mem_ready, mem_we, mem_re, mem_page, mem_rvalid, tx_valid;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb;
   tss_slot_s in_slot;
   logic [11:0] mem_addr;
   logic [7:0] mem_wdata, mem_wmask, mem_rdata, tx_byte;
   int num_errors, n_tests, n_we, n_tx, e_we, e_tx, n_from, i, k;
   // Reserved field bits left clear in every case
   localparam logic [6:0] tf [7] = '{7'h6a, 7'h47, 7'h23, 7'h38, 7'h18, 7'h11, 7'h00};
   localparam logic [7:0] td [7] = '{8'h20, 8'hfe, 8'h02, 8'h40, 8'ha5, 8'h3c, 8'h5a};
   localparam logic [7:0] tp [7] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h11, 8'ha5};
   localparam logic [7:0] te [7] = '{8'h04, 8'h7f, 8'h80, 8'hfd, 8'h0a, 8'hc1, 8'h5a};

   tss_shuffler DUT (.aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
      .wstrb, .bvalid, .bready(1'b1), .bresp, .arvalid, .arready, .araddr, .rvalid, .rready(1'b1),
      .rdata, .rresp, .frame_pulse, .in_valid, .in_ready, .in_slot, .mem_ready, .mem_we, .mem_re,
      .mem_page, .mem_addr, .mem_wdata, .mem_wmask, .mem_rvalid, .mem_rdata, .tx_valid, .tx_byte);
   tss_mem_model mem (.aclk, .stall, .mem_we, .mem_re, .mem_page, .mem_addr, .mem_wdata, .mem_wmask,
      .mem_ready, .mem_rvalid, .mem_rdata);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (mem_we === 1'b1) n_we <= n_we + 1;
      if (tx_valid === 1'b1) n_tx <= n_tx + 1;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic hang(input string nm);
      num_errors++;
      $display("[FAIL] %s expected answer seen none", nm);
      finish_test();
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int j;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (j = 0; j < 100; j++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (j == 100) hang("write");
      chk("bresp", er, bresp);
   endtask
   task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      int j;
      araddr <= a;
      arvalid <= 1'b1;
      for (j = 0; j < 100; j++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (j == 100) hang("read");
      chk("rdata", ed, rdata);
      chk("rresp", er, rresp);
   endtask
   // Leaves in_valid high so slots can follow back to back
   task automatic slot(input logic t, input logic p, input logic [11:0] a, input logic [6:0] f, input logic [7:0] d);
      int j;
      in_slot <= '{t, p, a, f, d};
      in_valid <= 1'b1;
      for (j = 0; j < 100; j++) begin
         @(posedge aclk);
         if (in_ready === 1'b1) break;
      end
      if (j == 100) hang("slot");
      if (t) e_tx++;
      else begin
         e_we++;
         n_from++;
      end
   endtask
   task automatic sync();
      int j;
      in_valid <= 1'b0;
      for (j = 0; j < 300; j++) begin
         @(negedge aclk);
         if (n_we == e_we && n_tx == e_tx) break;
      end
      @(posedge aclk);
      if (j == 300) hang("memory traffic");
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, arvalid, frame_pulse, in_valid, stall} = '0;
      awaddr = '0;
      wstrb = 4'hf;
      wdata = '0;
      araddr = '0;
      in_slot = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_rd(TSS_MODE_ADDR, 32'h0, TSS_RESP_OKAY);
      axi_rd(32'h400, 32'h0, TSS_RESP_SLVERR);
      axi_wr(32'h400, 32'h81, TSS_RESP_SLVERR);
      axi_wr(TSS_STAT_ADDR, 32'h1, TSS_RESP_OKAY);
      slot(0, 0, 12'h020, 7'h6a, 8'h5c);
      slot(1, 0, 12'h020, 7'h47, 8'h00);
      sync();
      chk("plain byte", 8'h5c, mem.m[0][12'h020]);
      chk("tx plain", 8'h5c, tx_byte);
      axi_wr(TSS_MODE_ADDR, 32'h80, TSS_RESP_OKAY);
      axi_rd(TSS_MODE_ADDR, 32'h80, TSS_RESP_OKAY);
      for (i = 0; i < 7; i++) begin
         slot(0, 0, 12'h040 + 12'(i), 7'h00, tp[i]);
         slot(0, 0, 12'h040 + 12'(i), tf[i], td[i]);
         sync();
         chk("shuffle", te[i], mem.m[0][12'h040 + 12'(i)]);
      end
      slot(0, 0, 12'h050, 7'h00, 8'h30);
      slot(0, 0, 12'h050, 7'h23, 8'h01);
      slot(0, 0, 12'h050, 7'h21, 8'h02);
      slot(0, 0, 12'h050, 7'h28, 8'h0c);
      slot(0, 0, 12'h050, 7'h32, 8'hcf);
      slot(1, 1, 12'h050, 7'h6a, 8'hff);
      sync();
      chk("packed tx", 8'h4b, tx_byte);
      // Memory stalled so the FIFO must refuse once full
      stall <= 1'b1;
      in_slot <= '{1'b0, 1'b0, 12'h060, 7'h00, 8'h00};
      in_valid <= 1'b1;
      k = 0;
      repeat (12) begin
         @(posedge aclk);
         if (in_ready === 1'b1) begin
            k++;
            in_slot.data <= 8'(k);
         end
      end
      chk("fifo fill", TSS_FIFO_DEPTH, k);
      stall <= 1'b0;
      e_we += k;
      n_from += k;
      sync();
      chk("drain order", 32'(k - 1), mem.m[0][12'h060]);
      axi_wr(TSS_MODE_ADDR, 32'h81, TSS_RESP_OKAY);
      slot(0, 1, 12'h010, 7'h00, 8'h77);
      slot(0, 1, 12'h011, 7'h47, 8'h01);
      sync();
      chk("active page", 8'h77, mem.m[0][12'h010]);
      chk("chosen page", 8'h80, mem.m[1][12'h011]);
      frame_pulse <= 1'b1;
      @(posedge aclk);
      frame_pulse <= 1'b0;
      slot(1, 0, 12'h011, 7'h00, 8'h00);
      sync();
      chk("page tx", 8'h80, tx_byte);
      // Lane 0 strobe low: the mode byte must stay as it was
      wstrb <= 4'he;
      axi_wr(TSS_MODE_ADDR, 32'h00, TSS_RESP_OKAY);
      wstrb <= 4'hf;
      axi_rd(TSS_MODE_ADDR, 32'h81, TSS_RESP_OKAY);
      axi_rd(TSS_STAT_ADDR, {n_from[15:0], 16'h0001}, TSS_RESP_OKAY);
      finish_test();
   end
endmodule // tb_top
